// file: ledsq_pkg.sv
// Shared constants for the LED string converter sequencer and its controller
package ledsq_pkg;
    localparam int unsigned CLK_HZ         = 25_000_000;
    localparam int unsigned SAR_HZ         = 1_000_000;
    localparam int unsigned SAR_DIV        = CLK_HZ / SAR_HZ;
    localparam int unsigned WINDOW_MS      = 190;
    localparam int unsigned WINDOW_TICKS   = WINDOW_MS * (SAR_HZ / 1000);
    localparam int unsigned DIM_MAX_HZ     = 100_000;
    localparam int unsigned DIM_PERIOD     = CLK_HZ / DIM_MAX_HZ;
    localparam int unsigned MIN_ON_US      = 2;
    localparam int unsigned MIN_ON_CYC     = (MIN_ON_US * CLK_HZ + 999_999) / 1_000_000;
    localparam int unsigned CUM_ON_US      = 10;
    localparam int unsigned REF_MIN_MV     = 97;
    localparam int unsigned REF_MAX_MV     = 316;

    localparam int unsigned NUM_STRINGS    = 4;
    localparam int unsigned NUM_CHANNELS   = 5;
    localparam int unsigned SAR_BITS       = 7;
    localparam logic [2:0]  CH_OUTPUT      = 3'h4;
    localparam logic [6:0]  SAR_START      = 7'h40;
    localparam logic [6:0]  FULL_SCALE     = 7'h7f;
    localparam int unsigned TIMEOUT_BIT    = 7;

    // Device register map, reached over the link
    localparam logic [3:0]  REG_REF_BASE   = 4'h0;
    localparam logic [3:0]  REG_STANDBY    = 4'h4;
    localparam logic [3:0]  REG_SAMPLE_BASE = 4'h5;
    localparam logic [3:0]  REG_FAULT      = 4'ha;
    localparam logic [6:0]  REF_RESET      = 7'h00;
    localparam int unsigned FAULT_OV_BIT   = 4;

    // Controller register map on Wishbone
    localparam logic [7:0]  WB_CMD         = 8'h00;
    localparam logic [7:0]  WB_STATUS      = 8'h04;
    localparam logic [7:0]  WB_DUTY        = 8'h08;
    localparam logic [7:0]  WB_LIMIT       = 8'h0c;
    localparam int unsigned CMD_WE_BIT     = 8;
    localparam int unsigned CMD_DATA_LSB   = 16;
endpackage : ledsq_pkg

// file: ledsq_if.sv
// Link between the controller and the converter sequencer
`timescale 1ns/1ns
interface ledsq_if;
    logic [3:0] dim;
    logic       req;
    logic       we;
    logic [3:0] addr;
    logic [7:0] wdata;
    logic       ack;
    logic [7:0] rdata;

    modport dev  (input dim, input req, input we, input addr, input wdata,
                  output ack, output rdata);
    modport host (output dim, output req, output we, output addr, output wdata,
                  input ack, input rdata);
endinterface : ledsq_if

// file: ledsq_device.sv
// Converter sequencer with result and fault registers, device end of the link
`timescale 1ns/1ns
module ledsq_device #(
    parameter int unsigned WINDOW_TICKS = ledsq_pkg::WINDOW_TICKS
) (
    ledsq_if.dev       link,
    input  wire logic  clk,
    input  wire logic  arst_n,
    input  wire logic  undervoltage_lockout,
    input  wire logic  shutdown_state,
    input  wire logic  overvoltage_trip,
    input  wire logic [3:0] short_trip,
    input  wire logic [3:0] current_regulated,
    input  wire logic  sar_compare_hi,
    output logic [2:0] mux_channel,
    output logic [6:0] sar_trial_code,
    output logic [3:0] sink_gate_drive,
    output logic [27:0] sink_reference_codes,
    output logic       regulator_latch_off,
    output logic       standby_state
);
    localparam int unsigned SYNC_W = 16;
    localparam logic [4:0] DIV_LAST = 5'(ledsq_pkg::SAR_DIV - 1);
    localparam logic [17:0] WIN_LAST = 18'(WINDOW_TICKS - 1);

    logic [SYNC_W-1:0] meta_r;
    logic [SYNC_W-1:0] sync_r;
    logic [3:0]        dim_s;
    logic [3:0]        short_s;
    logic [3:0]        regd_s;
    logic              undervoltage_lockout_s;
    logic              shutdown_state_s;
    logic              ov_s;
    logic              cmp_s;

    always_ff @(posedge clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            meta_r <= '0;
            sync_r <= '0;
        end
        else
        begin
            meta_r <= {sar_compare_hi, overvoltage_trip, shutdown_state, undervoltage_lockout,
                       current_regulated, short_trip, link.dim};
            sync_r <= meta_r;
        end
    end

    assign dim_s   = sync_r[3:0];
    assign short_s = sync_r[7:4];
    assign regd_s  = sync_r[11:8];
    assign undervoltage_lockout_s  = sync_r[12];
    assign shutdown_state_s  = sync_r[13];
    assign ov_s    = sync_r[14];
    assign cmp_s   = sync_r[15];

    // 1MHz step enable
    logic [4:0] div_r;
    logic       tick;

    always_ff @(posedge clk or negedge arst_n)
    begin
        if (!arst_n)
            div_r <= '0;
        else if (div_r == DIV_LAST)
            div_r <= '0;
        else
            div_r <= div_r + 5'h1;
    end

    assign tick = (div_r == DIV_LAST);

    // Registers written by the controller
    logic [6:0] ref_r [4];
    logic       standby_r;
    logic       take;
    logic       take_rd;

    assign take    = link.req & ~link.ack;
    assign take_rd = take & ~link.we;

    always_ff @(posedge clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            for (int i = 0; i < 4; i++)
                ref_r[i] <= ledsq_pkg::REF_RESET;
            standby_r <= 1'b0;
        end
        else if (take & link.we)
        begin
            for (int i = 0; i < 4; i++)
                if (link.addr == ledsq_pkg::REG_REF_BASE + 4'(i))
                    ref_r[i] <= link.wdata[6:0];
            if (link.addr == ledsq_pkg::REG_STANDBY)
                standby_r <= link.wdata[0];
        end
    end

    assign sink_reference_codes = {ref_r[3], ref_r[2], ref_r[1], ref_r[0]};
    assign standby_state        = standby_r;

    // Shorted-string lockout and fault record; enable low clears, set wins
    logic [3:0] locked_r;
    logic [3:0] short_new;
    logic       ov_fault_r;

    assign short_new = short_s & ~locked_r;

    always_ff @(posedge clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            locked_r   <= '0;
            ov_fault_r <= 1'b0;
        end
        else if (shutdown_state_s)
        begin
            locked_r   <= short_s;
            ov_fault_r <= ov_s;
        end
        else
        begin
            locked_r   <= locked_r | short_s;
            ov_fault_r <= ov_fault_r | ov_s;
        end
    end

    assign regulator_latch_off = ov_fault_r;

    // Channel selector and successive approximation
    typedef enum logic [0:0] {LEDSQ_HALT, LEDSQ_CONV} ledsq_state_e;
    ledsq_state_e state_r;
    logic [2:0]  ch_r;
    logic [6:0]  code_r;
    logic [2:0]  bit_r;
    logic [17:0] timer_r;
    logic        halt;
    logic        skip;
    logic        gate;
    logic        step;
    logic        finish;
    logic        expire;
    logic [6:0]  decided;
    logic [2:0]  ch_next;

    function automatic logic [2:0] next_channel(input logic [2:0] cur, input logic [3:0] lk);
        logic [2:0] c;
        c = cur;
        for (int k = 0; k < 5; k++)
        begin
            c = (c == ledsq_pkg::CH_OUTPUT) ? 3'h0 : c + 3'h1;
            if (c == ledsq_pkg::CH_OUTPUT || !lk[c[1:0]])
                break;
        end
        return c;
    endfunction : next_channel

    assign halt    = undervoltage_lockout_s | shutdown_state_s | standby_r;
    assign skip    = (ch_r != ledsq_pkg::CH_OUTPUT) && (locked_r[ch_r[1:0]] | short_s[ch_r[1:0]]);
    assign gate    = (ch_r == ledsq_pkg::CH_OUTPUT) ||
                     (dim_s[ch_r[1:0]] & regd_s[ch_r[1:0]]);
    // Halt masks the last step too, so an abort never writes the current result
    assign expire  = (state_r == LEDSQ_CONV) & ~halt & ~skip & tick &
                     (timer_r == WIN_LAST);
    assign step    = (state_r == LEDSQ_CONV) & ~halt & ~skip & tick & gate & ~expire;
    assign finish  = step & (bit_r == 3'h0);
    assign decided = cmp_s ? code_r : code_r & ~(7'h01 << bit_r);
    assign ch_next = next_channel(ch_r, locked_r | short_s);

    always_ff @(posedge clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            state_r <= LEDSQ_HALT;
            ch_r    <= 3'h0;
            code_r  <= ledsq_pkg::SAR_START;
            bit_r   <= 3'(ledsq_pkg::SAR_BITS - 1);
            timer_r <= '0;
        end
        else
        begin
            case (state_r)
                LEDSQ_HALT:
                    if (!halt)
                        state_r <= LEDSQ_CONV;
                LEDSQ_CONV:
                    if (halt)
                        state_r <= LEDSQ_HALT;
                default:
                    state_r <= LEDSQ_HALT;
            endcase
            if (halt || state_r != LEDSQ_CONV || skip || expire || finish)
            begin
                code_r  <= ledsq_pkg::SAR_START;
                bit_r   <= 3'(ledsq_pkg::SAR_BITS - 1);
                timer_r <= '0;
                if (!halt && state_r == LEDSQ_CONV && (skip || expire || finish))
                    ch_r <= ch_next;
            end
            else
            begin
                if (tick)
                    timer_r <= timer_r + 18'h1;
                if (step)
                begin
                    code_r <= decided | (7'h01 << (bit_r - 3'h1));
                    bit_r  <= bit_r - 3'h1;
                end
            end
        end
    end

    assign mux_channel    = ch_r;
    assign sar_trial_code = code_r;

    // Result registers
    logic [7:0] res_r [5];
    logic       pend_r;
    logic [2:0] pend_ch_r;
    logic [6:0] pend_val_r;
    logic       rd_hit;

    assign rd_hit = take_rd && (link.addr == ledsq_pkg::REG_SAMPLE_BASE + {1'b0, ch_r});

    always_ff @(posedge clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            for (int i = 0; i < 5; i++)
                res_r[i] <= 8'h00;
            pend_r     <= 1'b0;
            pend_ch_r  <= 3'h0;
            pend_val_r <= 7'h00;
        end
        else
        begin
            pend_r <= finish & rd_hit;
            if (finish && rd_hit)
            begin
                pend_ch_r  <= ch_r;
                pend_val_r <= decided;
            end
            if (pend_r)
                res_r[pend_ch_r] <= {1'b0, pend_val_r};
            if (finish && !rd_hit)
                res_r[ch_r] <= {1'b0, decided};
            if (expire)
                res_r[ch_r][ledsq_pkg::TIMEOUT_BIT] <= 1'b1;
            for (int i = 0; i < 4; i++)
                if (short_new[i])
                    res_r[i] <= {1'b0, ledsq_pkg::FULL_SCALE};
        end
    end

    // Register read port, answer one cycle after the request is taken
    logic       ack_r;
    logic [7:0] rdata_r;
    logic [3:0] sidx;

    assign sidx = link.addr - ledsq_pkg::REG_SAMPLE_BASE;

    always_ff @(posedge clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            ack_r   <= 1'b0;
            rdata_r <= 8'h00;
        end
        else
        begin
            ack_r <= take;
            if (take_rd)
            begin
                if (link.addr < ledsq_pkg::REG_STANDBY)
                    rdata_r <= {1'b0, ref_r[link.addr[1:0]]};
                else if (link.addr == ledsq_pkg::REG_STANDBY)
                    rdata_r <= {7'h00, standby_r};
                else if (link.addr < ledsq_pkg::REG_FAULT)
                    rdata_r <= res_r[sidx[2:0]];
                else if (link.addr == ledsq_pkg::REG_FAULT)
                    rdata_r <= {3'h0, ov_fault_r, locked_r};
                else
                    rdata_r <= 8'h00;
            end
        end
    end

    assign link.ack   = ack_r;
    assign link.rdata = rdata_r;

    // Gate drive follows dimming unless the string is locked off or the part is halted
    always_ff @(posedge clk or negedge arst_n)
    begin
        if (!arst_n)
            sink_gate_drive <= 4'h0;
        else
            sink_gate_drive <= dim_s & ~locked_r & ~short_s & {4{~halt}};
    end
endmodule : ledsq_device

// file: ledsq_host.sv
// Controller end: dimming generators, link master and result checks on Wishbone
`timescale 1ns/1ns
module ledsq_host (
    ledsq_if.host      link,
    input  wire logic  clk,
    input  wire logic  arst_n,
    input  wire logic  wb_cyc_i,
    input  wire logic  wb_stb_i,
    input  wire logic  wb_we_i,
    input  wire logic [7:0]  wb_adr_i,
    input  wire logic [31:0] wb_dat_i,
    input  wire logic [3:0]  wb_sel_i,
    output logic [31:0] wb_dat_o,
    output logic       wb_ack_o
);
    localparam logic [7:0] PER_LAST = 8'(ledsq_pkg::DIM_PERIOD - 1);
    localparam logic [7:0] MIN_ON   = 8'(ledsq_pkg::MIN_ON_CYC);
    localparam logic [7:0] PERIOD   = 8'(ledsq_pkg::DIM_PERIOD);

    logic       wb_take;
    logic [7:0] duty_r [4];
    logic [6:0] limit_r;
    logic       busy_r;
    logic [3:0] rd_addr_r;
    logic [7:0] last_r;
    logic [3:0] open_r;
    logic [3:0] over_r;

    assign wb_take = wb_cyc_i & wb_stb_i & ~wb_ack_o;

    always_ff @(posedge clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            for (int i = 0; i < 4; i++)
                duty_r[i] <= 8'h00;
            limit_r <= 7'h00;
        end
        else if (wb_take && wb_we_i)
        begin
            if (wb_adr_i == ledsq_pkg::WB_DUTY)
                for (int i = 0; i < 4; i++)
                    if (wb_sel_i[i])
                        duty_r[i] <= wb_dat_i[8*i +: 8];
            if (wb_adr_i == ledsq_pkg::WB_LIMIT && wb_sel_i[0])
                limit_r <= wb_dat_i[6:0];
        end
    end

    // Shared 100kHz frame; nonzero duty is stretched to the minimum pulse
    logic [7:0] pwm_cnt_r;
    logic [3:0] dim_r;

    always_ff @(posedge clk or negedge arst_n)
    begin
        if (!arst_n)
            pwm_cnt_r <= 8'h00;
        else if (pwm_cnt_r == PER_LAST)
            pwm_cnt_r <= 8'h00;
        else
            pwm_cnt_r <= pwm_cnt_r + 8'h01;
    end

    generate
        for (genvar g = 0; g < 4; g++)
        begin : g_dim
            logic [7:0] eff;
            assign eff = (duty_r[g] != 8'h00 && duty_r[g] < MIN_ON) ? MIN_ON : duty_r[g];
            always_ff @(posedge clk or negedge arst_n)
            begin
                if (!arst_n)
                    dim_r[g] <= 1'b0;
                else
                    dim_r[g] <= (pwm_cnt_r < eff) || (eff >= PERIOD);
            end
        end
    endgenerate

    assign link.dim = dim_r;

    // Link master: one request in flight, released on acknowledge
    logic       req_r;
    logic       we_r;
    logic [3:0] addr_r;
    logic [7:0] wdata_r;
    logic [6:0] meas;
    logic [3:0] sidx;

    assign meas = link.rdata[6:0];
    assign sidx = rd_addr_r - ledsq_pkg::REG_SAMPLE_BASE;

    always_ff @(posedge clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            req_r     <= 1'b0;
            we_r      <= 1'b0;
            addr_r    <= 4'h0;
            wdata_r   <= 8'h00;
            busy_r    <= 1'b0;
            rd_addr_r <= 4'h0;
            last_r    <= 8'h00;
            open_r    <= 4'h0;
            over_r    <= 4'h0;
        end
        else if (busy_r)
        begin
            if (link.ack)
            begin
                req_r  <= 1'b0;
                busy_r <= 1'b0;
                if (!we_r)
                begin
                    last_r <= link.rdata;
                    if (rd_addr_r >= ledsq_pkg::REG_SAMPLE_BASE &&
                        rd_addr_r < ledsq_pkg::REG_SAMPLE_BASE + 4'h4)
                    begin
                        open_r[sidx[1:0]] <= (link.rdata[ledsq_pkg::TIMEOUT_BIT] &&
                                              duty_r[sidx[1:0]] >= MIN_ON) ||
                                             (meas == 7'h00);
                        over_r[sidx[1:0]] <= meas > limit_r;
                    end
                end
            end
        end
        else if (wb_take && wb_we_i && wb_adr_i == ledsq_pkg::WB_CMD && wb_sel_i[0])
        begin
            req_r     <= 1'b1;
            busy_r    <= 1'b1;
            we_r      <= wb_dat_i[ledsq_pkg::CMD_WE_BIT];
            addr_r    <= wb_dat_i[3:0];
            rd_addr_r <= wb_dat_i[3:0];
            wdata_r   <= wb_dat_i[ledsq_pkg::CMD_DATA_LSB +: 8];
        end
    end

    assign link.req   = req_r;
    assign link.we    = we_r;
    assign link.addr  = addr_r;
    assign link.wdata = wdata_r;

    // Wishbone answer one cycle after strobe
    always_ff @(posedge clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            wb_ack_o <= 1'b0;
            wb_dat_o <= 32'h0000_0000;
        end
        else
        begin
            wb_ack_o <= wb_take;
            if (wb_take && !wb_we_i)
            begin
                case (wb_adr_i)
                    ledsq_pkg::WB_STATUS: wb_dat_o <= {8'h00, over_r, open_r, last_r, 7'h00, busy_r};
                    ledsq_pkg::WB_DUTY:   wb_dat_o <= {duty_r[3], duty_r[2], duty_r[1], duty_r[0]};
                    ledsq_pkg::WB_LIMIT:  wb_dat_o <= {25'h000_0000, limit_r};
                    default:              wb_dat_o <= 32'h0000_0000;
                endcase
            end
        end
    end
endmodule : ledsq_host

// file: ledsq_asserts.sv
// Link protocol checker between controller and sequencer
`timescale 1ns/1ns
module ledsq_asserts (
    input wire logic       clk,
    input wire logic       arst_n,
    input wire logic [3:0] dim,
    input wire logic       req,
    input wire logic       we,
    input wire logic [3:0] addr,
    input wire logic [7:0] wdata,
    input wire logic       ack,
    input wire logic [7:0] rdata
);
    logic rd_ack;
    assign rd_ack = ack && !we;
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!arst_n);

    chk_ack_next: assert property (req && !ack |=> ack)
        else $error("no answer one cycle after a request");
    chk_ack_pulse: assert property (ack |=> !ack)
        else $error("answer longer than one cycle");
    chk_ack_cause: assert property (ack |-> $past(req))
        else $error("answer without a request");
    chk_req_hold: assert property (req && !ack |=> req && $stable(addr) && $stable(we)
        && $stable(wdata))
        else $error("request changed before its answer");
    chk_req_drop: assert property (ack |=> !req)
        else $error("request still up after its answer");
    chk_fault_bits: assert property (rd_ack && addr == ledsq_pkg::REG_FAULT
        |-> rdata[7:5] == 3'h0)
        else $error("unused fault bits set");
    chk_unmapped_zero: assert property (rd_ack && addr > ledsq_pkg::REG_FAULT
        |-> rdata == 8'h00)
        else $error("unmapped index read nonzero");
    chk_standby_bit: assert property (rd_ack && addr == ledsq_pkg::REG_STANDBY
        |-> rdata[7:1] == 7'h00)
        else $error("standby readback has extra bits");
    chk_ref_width: assert property (rd_ack && addr < ledsq_pkg::REG_STANDBY
        |-> !rdata[7])
        else $error("reference code wider than seven bits");
    cov_dim_on: cover property ($rose(dim[0]));
endmodule : ledsq_asserts

// file: ledsq_tb_top.sv
// Self-checking bench: controller and sequencer joined over the link
`timescale 1ns/1ns
module ledsq_tb_top;
    localparam int WT = 40;
    logic        clk, arst_n, undervoltage_lockout, shutdown_state, overvoltage_trip;
    logic        sar_compare_hi, regulator_latch_off, standby_state;
    logic        wb_cyc, wb_stb, wb_we, wb_ack;
    logic [3:0]  short_trip, current_regulated, sink_gate_drive, lock_m;
    logic [2:0]  mux_channel, prev_ch;
    logic [6:0]  sar_trial_code;
    logic [27:0] sink_reference_codes;
    logic [7:0]  wb_adr, b;
    logic [31:0] wb_dat_w, wb_dat_r, rd, seed;
    logic [6:0]  lvl [0:7];
    int          samp_m [0:4];
    int          miscompares, samples_checked, e, nx;

    ledsq_if link_if ();
    ledsq_device #(.WINDOW_TICKS(WT)) ledsq_device_inst (.link(link_if), .clk(clk),
        .arst_n(arst_n), .undervoltage_lockout(undervoltage_lockout),
        .shutdown_state(shutdown_state), .overvoltage_trip(overvoltage_trip),
        .short_trip(short_trip), .current_regulated(current_regulated),
        .sar_compare_hi(sar_compare_hi), .mux_channel(mux_channel),
        .sar_trial_code(sar_trial_code), .sink_gate_drive(sink_gate_drive),
        .sink_reference_codes(sink_reference_codes),
        .regulator_latch_off(regulator_latch_off), .standby_state(standby_state));
    ledsq_host ledsq_host_inst (.link(link_if), .clk(clk), .arst_n(arst_n),
        .wb_cyc_i(wb_cyc), .wb_stb_i(wb_stb), .wb_we_i(wb_we), .wb_adr_i(wb_adr),
        .wb_dat_i(wb_dat_w), .wb_sel_i(4'hf), .wb_dat_o(wb_dat_r), .wb_ack_o(wb_ack));
    ledsq_asserts ledsq_asserts_inst (.clk(clk), .arst_n(arst_n), .dim(link_if.dim),
        .req(link_if.req), .we(link_if.we), .addr(link_if.addr), .wdata(link_if.wdata),
        .ack(link_if.ack), .rdata(link_if.rdata));

    always #20 clk = ~clk;
    // Ideal comparator: the converter should settle on the channel's level
    always @(posedge clk) sar_compare_hi <= lvl[mux_channel] >= sar_trial_code;

    function automatic logic [31:0] lfsr(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction : lfsr

    task automatic cmp(input string n, input logic [7:0] x, input logic [7:0] g);
        samples_checked++;
        if (g !== x)
        begin
            miscompares++;
            $display("ERROR %s expected %h seen %h", n, x, g);
        end
    endtask : cmp

    task automatic report_and_stop;
        $display("miscompares %0d samples_checked %0d", miscompares, samples_checked);
        if (miscompares == 0 && samples_checked > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask : report_and_stop

    task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
        int n;
        n = 0;
        @(posedge clk);
        wb_cyc <= 1'b1;
        wb_stb <= 1'b1;
        wb_we <= w;
        wb_adr <= a;
        wb_dat_w <= d;
        do
        begin
            @(posedge clk);
            n++;
        end
        while (wb_ack !== 1'b1 && n < 50);
        cmp("wb ack", 8'h01, {7'h00, wb_ack});
        rd = wb_dat_r;
        wb_cyc <= 1'b0;
        wb_stb <= 1'b0;
    endtask : wb

    task automatic dev(input logic [3:0] i, input logic w, input logic [7:0] d);
        int n;
        n = 0;
        wb(1'b1, ledsq_pkg::WB_CMD, {8'h00, d, 7'h00, w, 4'h0, i});
        do
        begin
            wb(1'b0, ledsq_pkg::WB_STATUS, 32'h0000_0000);
            n++;
        end
        while (rd[0] !== 1'b0 && n < 50);
        cmp("link idle", 8'h00, {7'h00, rd[0]});
        b = rd[15:8];
    endtask : dev

    task automatic chk_samples;
        logic [3:0] op, ov;
        for (int c = 0; c < 5; c++)
        begin
            dev(ledsq_pkg::REG_SAMPLE_BASE + 4'(c), 1'b0, 8'h00);
            cmp("sample", samp_m[c][7:0], b);
            if (c < 4)
                op[c] = samp_m[c][7] || samp_m[c][6:0] == 0;
            if (c < 4)
                ov[c] = samp_m[c][6:0] > 64;
        end
        cmp("open flags", {4'h0, op}, {4'h0, rd[19:16]});
        cmp("over flags", {4'h0, ov}, {4'h0, rd[23:20]});
    endtask : chk_samples

    // Selector must step in order and pass over locked strings
    always @(posedge clk)
    begin
        if (arst_n && mux_channel !== prev_ch)
        begin
            nx = prev_ch;
            do nx = (nx + 1) % 5; while (nx < 4 && lock_m[nx]);
            cmp("channel", 8'(nx), {5'h00, mux_channel});
        end
        prev_ch = mux_channel;
    end

    initial
    begin
        #(60_000 * 40);
        miscompares++;
        report_and_stop;
    end

    initial
    begin
        {clk, arst_n, undervoltage_lockout, shutdown_state, overvoltage_trip} = 5'h00;
        {wb_cyc, wb_stb, wb_we, sar_compare_hi, wb_adr, wb_dat_w} = 44'h0;
        {short_trip, current_regulated, lock_m, prev_ch} = 15'h0000;
        {miscompares, samples_checked} = 0;
        seed = 32'hb1c1_4c5f;
        for (int c = 0; c < 8; c++)
            lvl[c] = 7'h00;
        repeat (8) @(posedge clk);
        arst_n <= 1'b1;
        repeat (4) @(posedge clk);
        for (int i = 0; i < 4; i++)
        begin
            seed = lfsr(seed);
            dev(4'(i), 1'b1, {1'b0, seed[6:0]});
            dev(4'(i), 1'b0, 8'h00);
            cmp("ref", {1'b0, seed[6:0]}, b);
            cmp("ref pin", {1'b0, seed[6:0]}, {1'b0, sink_reference_codes[i*7 +: 7]});
        end
        dev(4'hc, 1'b0, 8'h00);
        cmp("unmapped dev", 8'h00, b);
        wb(1'b0, 8'h10, 32'h0000_0000);
        cmp("unmapped wb", 8'h00, rd[7:0]);
        wb(1'b1, ledsq_pkg::WB_LIMIT, 32'h0000_0040);
        wb(1'b1, ledsq_pkg::WB_DUTY, 32'hffff_ffff);
        current_regulated <= 4'hf;
        for (int c = 0; c < 5; c++)
        begin
            seed = lfsr(seed);
            lvl[c] = seed[6:0] | 7'h01;
            samp_m[c] = lvl[c];
        end
        repeat (3000) @(posedge clk);
        chk_samples;
        current_regulated[1] <= 1'b0;
        samp_m[1] = samp_m[1] | 128;
        repeat (2500) @(posedge clk);
        chk_samples;
        current_regulated[1] <= 1'b1;
        samp_m[1] = lvl[1];
        e = 0;
        while (mux_channel !== 3'h2 && e < 5000)
        begin
            @(posedge clk);
            e++;
        end
        cmp("reach string3", 8'h02, {5'h00, mux_channel});
        short_trip[2] <= 1'b1;
        lock_m[2] <= 1'b1;
        samp_m[2] = 8'h7f;
        repeat (10) @(posedge clk);
        short_trip[2] <= 1'b0;
        repeat (1500) @(posedge clk);
        chk_samples;
        dev(ledsq_pkg::REG_FAULT, 1'b0, 8'h00);
        cmp("fault short", 8'h04, b);
        cmp("drive", 8'h0b, {4'h0, sink_gate_drive});
        overvoltage_trip <= 1'b1;
        repeat (5) @(posedge clk);
        overvoltage_trip <= 1'b0;
        repeat (5) @(posedge clk);
        cmp("latch off", 8'h01, {7'h00, regulator_latch_off});
        dev(ledsq_pkg::REG_FAULT, 1'b0, 8'h00);
        cmp("fault ov", 8'h14, b);
        for (int k = 0; k < 3; k++)
        begin
            if (k == 0)
                dev(ledsq_pkg::REG_STANDBY, 1'b1, 8'h01);
            if (k == 1)
                undervoltage_lockout <= 1'b1;
            if (k == 2)
                shutdown_state <= 1'b1;
            repeat (10) @(posedge clk);
            if (k == 2)
                lock_m = 4'h0;
            if (k == 0)
                cmp("standby", 8'h01, {7'h00, standby_state});
            cmp("halt drive", 8'h00, {4'h0, sink_gate_drive});
            // New levels only after the halt is seen, so no late result can mix them
            for (int c = 0; c < 5; c++)
            begin
                seed = lfsr(seed);
                lvl[c] = seed[6:0] | 7'h01;
            end
            repeat (1500) @(posedge clk);
            chk_samples;
            if (k == 0)
                dev(ledsq_pkg::REG_STANDBY, 1'b1, 8'h00);
            undervoltage_lockout <= 1'b0;
            shutdown_state <= 1'b0;
            repeat (3000) @(posedge clk);
            for (int c = 0; c < 5; c++)
                if (c == 4 || !lock_m[c])
                    samp_m[c] = lvl[c];
            chk_samples;
        end
        dev(ledsq_pkg::REG_FAULT, 1'b0, 8'h00);
        cmp("fault cleared", 8'h00, b);
        report_and_stop;
    end
endmodule : ledsq_tb_top
